/* File: hw/ebu_collapsing_wbuf.sv */
// External bus unit: two-half collapsing write buffer, bus beat queue and read path.
// Assumes the bus slave answers each accepted read with one bus_rvalid pulse.
`timescale 1ns/1ps
module ebu_collapsing_wbuf #(
  parameter int FIFO_DEPTH = ebu_pkg::EBU_FIFO_DEPTH
) (
  input  wire logic                          mclk,                // Core clock.
  input  wire logic                          rst_n,               // Asynchronous reset, active low.
  input  wire logic                          cfg_full_merge,      // Static: 1 full merge, 0 no merge.
  input  wire logic                          aligned_enable_mode, // Static: aligned byte enables on writes and uncached tri-byte loads.
  input  wire logic                          core_valid,          // Core request present.
  output logic                               core_ready,          // Request taken this cycle.
  input  wire ebu_pkg::ebu_core_req_t        core_req,            // Core request fields.
  output logic                               load_valid,          // Load data pulse.
  output logic [ebu_pkg::EBU_DATA_W-1:0]     load_data,           // Load data.
  output logic                               bus_valid,           // Bus beat offered.
  input  wire logic                          bus_ready,           // Slave takes the beat.
  output ebu_pkg::ebu_bus_beat_t             bus_beat,            // Beat fields.
  input  wire logic                          bus_rvalid,          // Read data pulse from slave.
  input  wire logic [ebu_pkg::EBU_DATA_W-1:0] bus_rdata           // Read data from slave.
);
  import ebu_pkg::*;

  logic                       merge_full;
  logic                       abe_mode;
  logic                       cfg_taken;
  logic                       acc_valid;
  logic                       acc_unc;
  logic [EBU_LINE_W-1:0]      acc_line;
  logic [EBU_LINE_BE_W-1:0]   acc_be;
  logic [EBU_LINE_DATA_W-1:0] acc_data;
  logic                       drn_busy;
  logic [EBU_LINE_W-1:0]      drn_line;
  logic [EBU_LINE_BE_W-1:0]   drn_be;
  logic [EBU_LINE_DATA_W-1:0] drn_data;
  logic [EBU_WSEL_W-1:0]      drn_word;
  logic                       drn_half;
  ebu_rd_state_t              rd_state;

  logic [EBU_LINE_W-1:0]      req_line;
  logic [EBU_WSEL_W-1:0]      req_word;
  logic [EBU_BE_W-1:0]        slot_be;
  logic                       same_line;
  logic                       is_store;
  logic                       is_load;
  logic                       is_sync;
  logic                       store_blocks;
  logic                       load_blocks;
  logic                       acc_full;
  logic                       acc_push_req;
  logic                       handoff;
  logic                       bus_quiet;
  logic                       load_take;
  logic [EBU_BE_W-1:0]        cur_be;
  logic                       split_needed;
  logic                       drn_advance;
  logic                       fifo_in_valid;
  logic                       fifo_in_ready;
  logic                       fifo_out_valid;
  logic                       fifo_out_ready;
  ebu_bus_beat_t              fifo_in_beat;
  ebu_bus_beat_t              fifo_out_beat;
  ebu_bus_beat_t              read_beat;

  function automatic logic is_simple(input logic [EBU_BE_W-1:0] be);
    case (be)
      EBU_BE_B0, EBU_BE_B1, EBU_BE_B2, EBU_BE_B3, EBU_BE_LO, EBU_BE_HI, EBU_BE_ALL: is_simple = 1'b1;
      default: is_simple = 1'b0;
    endcase
  endfunction : is_simple

  // Settings are static; taking them once avoids a mode change with data in flight.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      merge_full <= 1'b0;
      abe_mode   <= 1'b0;
      cfg_taken  <= 1'b0;
    end else if (!cfg_taken) begin
      merge_full <= cfg_full_merge;
      abe_mode   <= aligned_enable_mode;
      cfg_taken  <= 1'b1;
    end
  end

  assign req_line  = core_req.addr[EBU_ADDR_W-1:EBU_OFS_W];
  assign req_word  = core_req.addr[EBU_OFS_W-1:EBU_WSEL_LSB];
  assign slot_be   = acc_be[req_word*EBU_BE_W +: EBU_BE_W];
  assign same_line = acc_valid && !acc_unc && (acc_line == req_line);
  assign is_store  = (core_req.op == EBU_OP_STORE);
  assign is_load   = (core_req.op == EBU_OP_LOAD);
  assign is_sync   = (core_req.op == EBU_OP_SYNC);
  assign acc_full  = (acc_be == EBU_LINE_BE_ALL);

  // Write-back words merge freely so a dirty line always collects its four words.
  assign store_blocks = acc_valid && (!same_line || core_req.unc
                        || (!merge_full && !core_req.wb && (slot_be != EBU_BE_NONE)));
  assign load_blocks  = acc_valid && (same_line || core_req.unc);

  assign acc_push_req = acc_valid && (acc_full || acc_unc
                        || (core_valid && cfg_taken && ((is_store && store_blocks)
                        || (is_load && load_blocks) || is_sync)));
  assign handoff      = acc_push_req && !drn_busy;
  assign bus_quiet    = !drn_busy && !fifo_out_valid && !bus_valid;

  // A handover waiting on a busy drain half holds the core here.
  always_comb begin
    core_ready = 1'b0;
    if (cfg_taken && (rd_state == EBU_RD_IDLE) && !(acc_valid && (acc_full || acc_unc))) begin
      case (core_req.op)
        EBU_OP_STORE: core_ready = !store_blocks;
        EBU_OP_LOAD:  core_ready = !load_blocks && bus_quiet;
        EBU_OP_SYNC:  core_ready = !acc_valid && bus_quiet;
        default:      core_ready = 1'b0;
      endcase
    end
  end
  assign load_take = core_valid && core_ready && is_load;

  // Gathering half.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_valid <= 1'b0;
      acc_unc   <= 1'b0;
      acc_line  <= '0;
      acc_be    <= '0;
      acc_data  <= '0;
    end else if (handoff) begin
      acc_valid <= 1'b0;
      acc_unc   <= 1'b0;
      acc_be    <= '0;
    end else if (core_valid && core_ready && is_store) begin
      acc_valid <= 1'b1;
      acc_unc   <= core_req.unc;
      acc_line  <= req_line;
      for (int b = 0; b < EBU_BE_W; b++) begin
        if (core_req.be[b]) begin
          acc_be[req_word*EBU_BE_W + b] <= 1'b1;
          acc_data[(req_word*EBU_BE_W + b)*EBU_BYTE_W +: EBU_BYTE_W] <= core_req.wdata[b*EBU_BYTE_W +: EBU_BYTE_W];
        end
      end
    end
  end

  // Drain half: walks the four words, skipping empty ones, splitting odd patterns.
  assign cur_be        = drn_be[drn_word*EBU_BE_W +: EBU_BE_W];
  assign split_needed  = abe_mode && !is_simple(cur_be);
  assign fifo_in_valid = drn_busy && (cur_be != EBU_BE_NONE);
  assign drn_advance   = drn_busy && ((cur_be == EBU_BE_NONE) || (fifo_in_ready && !(split_needed && !drn_half)));

  always_comb begin
    fifo_in_beat       = '0;
    fifo_in_beat.write = 1'b1;
    fifo_in_beat.addr  = {drn_line, drn_word, EBU_WORD_OFS0};
    fifo_in_beat.data  = drn_data[drn_word*EBU_DATA_W +: EBU_DATA_W];
    fifo_in_beat.last  = ((drn_be >> ((drn_word + 1)*EBU_BE_W)) == '0) && !(split_needed && !drn_half);
    if (split_needed) begin
      fifo_in_beat.bus_byte_enables = cur_be & (drn_half ? EBU_BE_HI : EBU_BE_LO);
    end else begin
      fifo_in_beat.bus_byte_enables = cur_be;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      drn_busy <= 1'b0;
      drn_line <= '0;
      drn_be   <= '0;
      drn_data <= '0;
      drn_word <= '0;
      drn_half <= 1'b0;
    end else if (handoff) begin
      drn_busy <= 1'b1;
      drn_line <= acc_line;
      drn_be   <= acc_be;
      drn_data <= acc_data;
      drn_word <= '0;
      drn_half <= 1'b0;
    end else if (drn_busy) begin
      if (fifo_in_valid && fifo_in_ready && split_needed && !drn_half) begin
        drn_half <= 1'b1;
      end else if (drn_advance) begin
        drn_half <= 1'b0;
        if (drn_word == EBU_WORD_LAST) begin
          drn_busy <= 1'b0;
        end else begin
          drn_word <= drn_word + 1'b1;
        end
      end
    end
  end

  ebu_fifo #(
    .WIDTH ($bits(ebu_bus_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_beat_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_beat),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_beat)
  );

  // Read beat; an uncached tri-byte load would present an odd pattern, so it widens.
  always_comb begin
    read_beat       = '0;
    read_beat.last  = 1'b1;
    read_beat.addr  = core_req.addr;
    read_beat.bus_byte_enables = core_req.be;
    if (abe_mode && core_req.unc && ($countones(core_req.be) == EBU_TRI_BYTES)) begin
      read_beat.bus_byte_enables = EBU_BE_ALL;
    end
  end

  assign fifo_out_ready = (rd_state == EBU_RD_IDLE) && (!bus_valid || bus_ready);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_valid <= 1'b0;
      bus_beat  <= '0;
    end else if (load_take) begin
      bus_valid <= 1'b1;
      bus_beat  <= read_beat;
    end else if (fifo_out_valid && fifo_out_ready) begin
      bus_valid <= 1'b1;
      bus_beat  <= fifo_out_beat;
    end else if (bus_ready) begin
      bus_valid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state   <= EBU_RD_IDLE;
      load_valid <= 1'b0;
      load_data  <= '0;
    end else begin
      load_valid <= 1'b0;
      case (rd_state)
        EBU_RD_IDLE: begin
          if (load_take) begin
            rd_state <= EBU_RD_WAIT;
          end
        end
        EBU_RD_WAIT: begin
          if (bus_rvalid) begin
            rd_state   <= EBU_RD_IDLE;
            load_valid <= 1'b1;
            load_data  <= bus_rdata;
          end
        end
        default: rd_state <= EBU_RD_IDLE;
      endcase
    end
  end

  AST_STALL_WHILE_DRAINING: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && is_store && store_blocks && drn_busy |-> !core_ready)
    else $error("store taken while handover waits on drain half");

  AST_FULL_LINE_HANDOFF: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_valid && acc_full && !drn_busy |=> !acc_valid && drn_busy && (drn_be == EBU_LINE_BE_ALL))
    else $error("full line not handed over");

  AST_ALIGNED_ENABLES: assert property (@(posedge mclk) disable iff (!rst_n)
    bus_valid && bus_beat.write && abe_mode |-> is_simple(bus_beat.bus_byte_enables))
    else $error("unaligned byte enables in aligned mode");

  AST_UNCACHED_ALONE: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && core_ready && is_store && acc_valid |-> !core_req.unc && !acc_unc)
    else $error("uncached store combined");

  AST_NOMERGE_SLOT: assert property (@(posedge mclk) disable iff (!rst_n)
    !merge_full && core_valid && core_ready && is_store && acc_valid && !core_req.wb |-> slot_be == EBU_BE_NONE)
    else $error("store merged into occupied word in no-merge mode");

  // A drain half that was still busy may finish on that same edge, so the handover comes a cycle later.
  AST_LOAD_SEES_STORES: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && is_load && same_line |-> !core_ready ##1 (!acc_valid || $past(drn_busy)))
    else $error("load to gathered line not flushed first");

  AST_TRIBYTE_WORD_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    load_take && abe_mode && core_req.unc && ($countones(core_req.be) == EBU_TRI_BYTES)
    |=> bus_valid && !bus_beat.write && (bus_beat.bus_byte_enables == EBU_BE_ALL))
    else $error("tri-byte uncached load not widened");

  AST_SPLIT_PAIR: assert property (@(posedge mclk) disable iff (!rst_n)
    fifo_in_valid && fifo_in_ready && split_needed && !drn_half |=> drn_half && fifo_in_valid)
    else $error("second part of split write missing");

  AST_SYNC_DRAINED: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && core_ready && is_sync |-> !acc_valid && !drn_busy)
    else $error("sync taken with buffered data");

  AST_NEW_LINE_HANDOFF: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && cfg_taken && is_store && acc_valid && !same_line && !drn_busy |=> !acc_valid)
    else $error("store to another line did not hand over");

  AST_UNCACHED_HANDOFF: assert property (@(posedge mclk) disable iff (!rst_n)
    acc_valid && acc_unc && !drn_busy |=> !acc_valid && drn_busy)
    else $error("uncached store not handed over alone");

  // Gathering must go on while the other half drains, or the two halves buy nothing.
  AST_GATHER_WHILE_DRAINING: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && is_store && same_line && !core_req.unc && merge_full && !acc_full
    && (rd_state == EBU_RD_IDLE) |-> core_ready)
    else $error("full merge store to gathered line refused");

  AST_WRITEBACK_MERGES: assert property (@(posedge mclk) disable iff (!rst_n)
    core_valid && is_store && core_req.wb && !core_req.unc && same_line && !acc_full
    && (rd_state == EBU_RD_IDLE) |-> core_ready)
    else $error("write-back word to gathered line refused");

  AST_SETTINGS_HELD: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg_taken |=> $stable(merge_full) && $stable(abe_mode))
    else $error("merge or aligned enable setting changed after capture");

endmodule : ebu_collapsing_wbuf

/* File: inc/ebu_pkg.sv */
// Shared constants and carrier types of the external bus unit and its write buffer.
// Assumes one clock domain; every user imports the whole package.
package ebu_pkg;

  localparam int          EBU_ADDR_W      = 32;
  localparam int          EBU_DATA_W      = 32;
  localparam int          EBU_BE_W        = 4;
  localparam int          EBU_OFS_W       = 4;
  localparam int          EBU_LINE_W      = EBU_ADDR_W - EBU_OFS_W;
  localparam int          EBU_WSEL_LSB    = 2;
  localparam int          EBU_WSEL_W      = EBU_OFS_W - EBU_WSEL_LSB;
  localparam int          EBU_WORDS       = 4;
  localparam int          EBU_BYTE_W      = 8;
  localparam int          EBU_LINE_BE_W   = EBU_WORDS * EBU_BE_W;
  localparam int          EBU_LINE_DATA_W = EBU_WORDS * EBU_DATA_W;
  localparam int          EBU_FIFO_DEPTH  = 32;
  localparam int          EBU_TRI_BYTES   = 3;

  localparam logic [EBU_BE_W-1:0]      EBU_BE_NONE = 4'h0;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_ALL  = 4'hf;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_LO   = 4'h3;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_HI   = 4'hc;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_B0   = 4'h1;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_B1   = 4'h2;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_B2   = 4'h4;
  localparam logic [EBU_BE_W-1:0]      EBU_BE_B3   = 4'h8;
  localparam logic [EBU_LINE_BE_W-1:0] EBU_LINE_BE_ALL = 16'hffff;
  localparam logic [EBU_WSEL_W-1:0]    EBU_WORD_LAST   = 2'h3;
  localparam logic [EBU_WSEL_LSB-1:0]  EBU_WORD_OFS0   = 2'h0;

  typedef enum logic [1:0] {EBU_OP_STORE, EBU_OP_LOAD, EBU_OP_SYNC} ebu_op_t;
  typedef enum logic {EBU_RD_IDLE, EBU_RD_WAIT} ebu_rd_state_t;

  typedef struct packed {
    ebu_op_t               op;
    logic                  unc;
    logic                  wb;
    logic [EBU_ADDR_W-1:0] addr;
    logic [EBU_BE_W-1:0]   be;
    logic [EBU_DATA_W-1:0] wdata;
  } ebu_core_req_t;

  typedef struct packed {
    logic                  write;
    logic                  last;
    logic [EBU_ADDR_W-1:0] addr;
    logic [EBU_BE_W-1:0]   bus_byte_enables;
    logic [EBU_DATA_W-1:0] data;
  } ebu_bus_beat_t;

endpackage : ebu_pkg

/* File: hw/ebu_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes a single clock; the reader may stall, so the FIFO really fills.
`timescale 1ns/1ps
module ebu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,      // Clock.
  input  wire logic             rst_n,     // Asynchronous reset, active low.
  input  wire logic             in_valid,  // Write request.
  output logic                  in_ready,  // Space available.
  input  wire logic [WIDTH-1:0] in_data,   // Write data.
  output logic                  out_valid, // Data available.
  input  wire logic             out_ready, // Reader takes the head word.
  output logic      [WIDTH-1:0] out_data   // Head word.
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0]   FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != FULL_CNT);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : ebu_fifo

/* File: tb/ebu_bus_slave.sv */
// Bus slave model for the external bus unit: takes beats with random stalls and answers reads.
// Assumes the bench drives hold on the falling edge; each accepted read gets one data pulse.
`timescale 1ns/1ps
module ebu_bus_slave (
  input  wire logic                          mclk,       // Clock.
  input  wire logic                          rst_n,      // Reset, active low.
  input  wire logic                          hold,       // Refuse every beat while high.
  input  wire logic                          bus_valid,  // Beat offered.
  output logic                               bus_ready,  // Beat taken.
  input  wire ebu_pkg::ebu_bus_beat_t        bus_beat,   // Beat fields.
  output logic                               bus_rvalid, // Read data pulse.
  output logic [ebu_pkg::EBU_DATA_W-1:0]     bus_rdata   // Read data.
);
  import ebu_pkg::*;
  logic                  took_rd;
  logic [EBU_ADDR_W-1:0] rd_addr;
  int                    cnt;
  always @(posedge mclk) begin
    took_rd = bus_valid && bus_ready && !bus_beat.write;
    if (took_rd) rd_addr = bus_beat.addr;
  end
  // Read data is a function of the word address so the bench can predict it.
  // Between pulses the data lines toggle, so stale data is never mistaken for an answer.
  always @(negedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt = 0;
      bus_rvalid = 1'b0;
      bus_ready = 1'b0;
      bus_rdata = 32'h0;
    end else begin
      bus_ready = !hold && ($urandom % 4 != 0);
      bus_rvalid = 1'b0;
      if (took_rd === 1'b1) cnt = 1 + $urandom % 4;
      else if (cnt > 0) begin
        cnt--;
        if (cnt == 0) begin
          bus_rvalid = 1'b1;
          bus_rdata = {rd_addr[31:2], 2'h0} ^ 32'ha5a5a5a5;
        end
      end
      if (!bus_rvalid) bus_rdata = ~bus_rdata;
    end
  end
endmodule : ebu_bus_slave

/* File: tb/ebu_collapsing_wbuf_tb.sv */
// Self-checking bench: drives core requests, predicts every bus beat and load result.
// Assumes ebu_bus_slave on the bus side; inputs change on the falling edge.
`timescale 1ns/1ps
module ebu_collapsing_wbuf_tb;
  import ebu_pkg::*;
  logic mclk, rst_n, cfg_full_merge, aligned_enable_mode, core_valid, core_ready, hold;
  logic load_valid, bus_valid, bus_ready, bus_rvalid;
  logic [31:0] load_data, bus_rdata;
  ebu_core_req_t core_req;
  ebu_bus_beat_t bus_beat;
  int err_count, n_checks;
  ebu_bus_beat_t exp_q[$];
  logic fm, al, acc_v;
  logic [EBU_LINE_W-1:0] acc_line;
  logic [15:0] acc_be;
  logic [127:0] acc_d;
  logic [3:0] be_tab[9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf, 4'h7, 4'he};

  ebu_collapsing_wbuf #(.FIFO_DEPTH(2)) i_ebu_collapsing_wbuf (.mclk(mclk), .rst_n(rst_n),
    .cfg_full_merge(cfg_full_merge), .aligned_enable_mode(aligned_enable_mode), .core_valid(core_valid),
    .core_ready(core_ready), .core_req(core_req), .load_valid(load_valid), .load_data(load_data),
    .bus_valid(bus_valid), .bus_ready(bus_ready), .bus_beat(bus_beat), .bus_rvalid(bus_rvalid),
    .bus_rdata(bus_rdata));
  ebu_bus_slave i_ebu_bus_slave (.mclk(mclk), .rst_n(rst_n), .hold(hold), .bus_valid(bus_valid),
    .bus_ready(bus_ready), .bus_beat(bus_beat), .bus_rvalid(bus_rvalid), .bus_rdata(bus_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic bad(string s);
    err_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask : bad

  function automatic logic simple(logic [3:0] be);
    return be inside {EBU_BE_B0, EBU_BE_B1, EBU_BE_B2, EBU_BE_B3, EBU_BE_LO, EBU_BE_HI, EBU_BE_ALL};
  endfunction : simple

  function automatic void push(logic w, logic l, logic [31:0] a, logic [3:0] be, logic [31:0] d);
    if (al && w && !simple(be)) begin
      exp_q.push_back('{w, 1'b0, a, be & EBU_BE_LO, d});
      exp_q.push_back('{w, l, a, be & EBU_BE_HI, d});
    end else exp_q.push_back('{w, l, a, be, d});
  endfunction : push

  // Gathered words leave in ascending order; empty words are skipped and last marks the final one.
  function automatic void flush();
    int lw;
    lw = 0;
    for (int i = 0; i < 4; i++) if (acc_be[i*4+:4] != 4'h0) lw = i;
    for (int i = 0; i < 4; i++)
      if (acc_v && acc_be[i*4+:4] != 4'h0) push(1'b1, i == lw, {acc_line, 2'(i), 2'h0}, acc_be[i*4+:4], acc_d[i*32+:32]);
    acc_v = 1'b0;
    acc_be = 16'h0;
  endfunction : flush

  function automatic void model(ebu_op_t o, logic unc, logic wb, logic [31:0] a, logic [3:0] be, logic [31:0] d);
    int w;
    w = a[3:2];
    if (o == EBU_OP_SYNC || unc || (o == EBU_OP_LOAD && acc_v && a[31:4] == acc_line)) flush();
    else if (o == EBU_OP_STORE && acc_v && (a[31:4] != acc_line || (!fm && !wb && acc_be[w*4+:4] != 4'h0)))
      flush();
    if (o == EBU_OP_LOAD) push(1'b0, 1'b1, a, (al && unc && $countones(be) == 3) ? EBU_BE_ALL : be, 32'h0);
    else if (o == EBU_OP_STORE) begin
      acc_v = 1'b1;
      acc_line = a[31:4];
      for (int i = 0; i < 4; i++) if (be[i]) begin
        acc_be[w*4+i] = 1'b1;
        acc_d[w*32+i*8+:8] = d[i*8+:8];
      end
      if (unc || acc_be == EBU_LINE_BE_ALL) flush();
    end
  endfunction : model

  always @(posedge mclk) begin
    ebu_bus_beat_t e;
    logic [31:0] m;
    if (rst_n && bus_valid && bus_ready) begin
      if (al && !simple(bus_beat.bus_byte_enables)) bad("irregular byte enables on bus");
      if (exp_q.size() == 0) bad("bus beat not predicted");
      else begin
        e = exp_q.pop_front();
        m = {{8{e.bus_byte_enables[3]}}, {8{e.bus_byte_enables[2]}}, {8{e.bus_byte_enables[1]}},
             {8{e.bus_byte_enables[0]}}};
        n_checks++;
        if (bus_beat.write !== e.write || bus_beat.last !== e.last || bus_beat.addr[31:2] !== e.addr[31:2] ||
            bus_beat.bus_byte_enables !== e.bus_byte_enables || (e.write && (bus_beat.data & m) !== (e.data & m)))
          bad("bus beat differs from model");
      end
    end
  end

  task automatic op(ebu_op_t o, logic unc, logic wb, logic [31:0] a, logic [3:0] be, logic [31:0] d);
    int k;
    core_valid = 1'b1;
    core_req = '{o, unc, wb, a, be, d};
    model(o, unc, wb, a, be, d);
    k = 0;
    #1;
    while (core_ready !== 1'b1 && k < 300) begin
      @(negedge mclk);
      #1;
      k++;
    end
    if (k == 300) bad("request never taken");
    @(negedge mclk);
    if (o == EBU_OP_LOAD) begin
      core_valid = 1'b0;
      k = 0;
      while (load_valid !== 1'b1 && k < 300) begin
        @(negedge mclk);
        k++;
      end
      if (k == 300) bad("load answer missing");
      n_checks++;
      if (load_data !== ({a[31:2], 2'h0} ^ 32'ha5a5a5a5)) bad("load data wrong");
    end
  endtask : op

  task automatic drain(string name);
    int k;
    core_valid = 1'b0;
    k = 0;
    while (exp_q.size() != 0 && k < 500) begin
      @(negedge mclk);
      k++;
    end
    if (exp_q.size() != 0) bad("predicted beats missing");
    $display("test %s done", name);
  endtask : drain

  task automatic restart(logic f, logic a);
    rst_n = 1'b0;
    core_valid = 1'b0;
    cfg_full_merge = f;
    aligned_enable_mode = a;
    fm = f;
    al = a;
    acc_v = 1'b0;
    acc_be = 16'h0;
    exp_q.delete();
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
  endtask : restart

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results

  initial begin
    #400000;
    bad("watchdog expired");
    results();
  end

  initial begin
    hold = 1'b0;
    core_req = '0;
    err_count = 0;
    n_checks = 0;
    void'($urandom(86073));
    restart(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) op(EBU_OP_STORE, 0, 0, 32'h1000 + 32'(4*i), 4'hf, $urandom);
    op(EBU_OP_STORE, 0, 0, 32'h2004, 4'h1, $urandom);
    op(EBU_OP_STORE, 0, 0, 32'h3000, 4'h3, $urandom);
    op(EBU_OP_SYNC, 0, 0, 32'h0, 4'h0, 32'h0);
    op(EBU_OP_STORE, 0, 0, 32'h4008, 4'hc, $urandom);
    op(EBU_OP_LOAD, 0, 0, 32'h4000, 4'hf, 32'h0);
    op(EBU_OP_STORE, 0, 0, 32'h5000, 4'h1, $urandom);
    op(EBU_OP_STORE, 1, 0, 32'h5000, 4'h2, $urandom);
    drain("basic");
    restart(1'b0, 1'b0);
    cfg_full_merge = 1'b1; // Must be ignored until the next reset.
    for (int i = 0; i < 4; i++) op(EBU_OP_STORE, 0, 1, 32'h6000 + 32'(4*i), 4'hf, $urandom);
    op(EBU_OP_STORE, 0, 0, 32'h6000, 4'h1, $urandom);
    op(EBU_OP_STORE, 0, 0, 32'h6000, 4'h2, $urandom);
    op(EBU_OP_STORE, 0, 0, 32'h6004, 4'hf, $urandom);
    op(EBU_OP_SYNC, 0, 0, 32'h0, 4'h0, 32'h0);
    drain("no merge");
    for (int c = 0; c < 2; c++) begin
      restart(c == 0, 1'b1);
      op(EBU_OP_STORE, 0, 0, 32'h8000, 4'h1, $urandom);
      op(EBU_OP_STORE, 0, 0, 32'h8000, 4'h4, $urandom);
      op(EBU_OP_STORE, 1, 0, 32'ha004, 4'he, $urandom);
      op(EBU_OP_LOAD, 1, 0, 32'ha008, 4'h7, 32'h0);
      op(EBU_OP_SYNC, 0, 0, 32'h0, 4'h0, 32'h0);
      drain("aligned enables");
    end
    // A stuck bus plus a two-entry queue keeps the drain half busy, so a second handover must wait.
    restart(1'b1, 1'b0);
    hold = 1'b1;
    for (int i = 0; i < 8; i++) op(EBU_OP_STORE, 0, 0, 32'h7000 + 32'(4*i), 4'hf, $urandom);
    core_valid = 1'b1;
    core_req = '{EBU_OP_STORE, 1'b0, 1'b0, 32'h9000, 4'hf, 32'h0};
    repeat (20) @(negedge mclk);
    n_checks++;
    if (core_ready !== 1'b0) bad("core not stalled behind busy drain half");
    hold = 1'b0;
    op(EBU_OP_STORE, 0, 0, 32'h9000, 4'hf, $urandom);
    drain("stall");
    for (int c = 0; c < 2; c++) begin
      restart(c == 0, c == 1);
      repeat (40) begin
        int r, u;
        r = $urandom % 8;
        u = ($urandom % 8 == 0);
        // Stores and uncached loads may carry a tri-byte pattern; cached loads keep to aligned ones.
        op(r < 6 ? EBU_OP_STORE : (r == 6 ? EBU_OP_LOAD : EBU_OP_SYNC), u[0], 0,
           {28'h00000b0 + 28'($urandom % 3), 2'($urandom), 2'h0},
           be_tab[$urandom % ((r == 6 && u == 0) ? 7 : 9)], $urandom);
      end
      op(EBU_OP_SYNC, 0, 0, 32'h0, 4'h0, 32'h0);
      drain("random");
    end
    results();
  end
endmodule : ebu_collapsing_wbuf_tb
